/* hdl/dram_init_pkg.sv */
// Purpose: Shared constants for the DRAM init timing and upper row map block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   Offsets of all registers are local choices
package dram_init_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] row_map_upper_off   = 8'h00;
   localparam logic [7:0] init_wait_ctrl_off  = 8'h04;
   localparam logic [7:0] rst_cke_lo_off      = 8'h08;
   localparam logic [7:0] rst_cke_hi_off      = 8'h0C;
   localparam logic [7:0] init_ctrl_off       = 8'h10;
   localparam logic [7:0] init_status_off     = 8'h14;
   // ==========================================================
   // Field positions
   localparam int row_b13_lsb     = 8;
   localparam int row_b14_lsb     = 4;
   localparam int row_b15_lsb     = 0;
   localparam int pre_cal_lsb     = 8;
   localparam int post_wait_lsb   = 1;
   localparam int skip_bit        = 0;
   localparam int pre_cke_lo_lsb  = 8;
   localparam int mem_rst_lsb     = 0;
   localparam int pre_cke_hi_lsb  = 0;
   // ==========================================================
   // Internal bases of the upper row bits
   localparam logic [4:0] row_b13_base = 5'h13;
   localparam logic [4:0] row_b14_base = 5'h14;
   localparam logic [4:0] row_b15_base = 5'h15;
   localparam logic [3:0] row_sel_off  = 4'hF;
   // ==========================================================
   // Reset values
   localparam logic [31:0] row_map_upper_rst  = 32'h0000_0000;
   localparam logic [31:0] init_wait_ctrl_rst = 32'h0000_0001;
   localparam logic [31:0] rst_cke_lo_rst     = 32'h0000_0000;
   localparam logic [31:0] rst_cke_hi_rst     = 32'h0000_0000;
   // ==========================================================
   // Tick sizes in controller clocks
   localparam int tick32_cycles   = 32;
   localparam int tick1024_cycles = 1024;
   // Fixed gap after clock enable and after the default command, in cycles
   localparam int cmd_gap_cycles  = 4;
   // ==========================================================
   // Init sequencer states, Gray coded along the path
   typedef enum logic [3:0] {
      st_idle     = 4'b0000,
      st_mem_rst  = 4'b0001,
      st_pre_cke  = 4'b0011,
      st_cke_on   = 4'b0010,
      st_cal_dflt = 4'b0110,
      st_pre_cal  = 4'b0111,
      st_cal_exit = 4'b0101,
      st_final    = 4'b0100,
      st_run      = 4'b1100
   } init_state_t;
   // Init commands shown to the command path
   typedef enum logic [1:0] {
      cmd_none     = 2'h0,
      cmd_cal_dflt = 2'h1,
      cmd_cal_exit = 2'h2,
      cmd_cal_adj  = 2'h3
   } init_cmd_t;
endpackage : dram_init_pkg

/* hdl/row_bit_select.sv */
// Purpose: Picks one upper row bit from the system address
// Assumes: Select values 0..11 valid, 15 forces zero
// Notes:   Out-of-range values 12..14 also give zero
`timescale 1ns/1ps
`default_nettype none
module row_bit_select #(
   parameter logic [4:0] base = 5'h13
) (
   input  wire logic [31:0] sys_addr,
   input  wire logic [3:0]  sel,
   output logic             row_bit
);
   import dram_init_pkg::*;
   logic [5:0] pos;   // Base plus field, one bit wider than an index
   // ==========================================================
   // Selection
   always_comb begin
      pos = {1'b0, base} + {2'b00, sel};
      // Illegal codes read as zero rather than aliasing high bits;
      // a sum past bit 31 names no address bit and reads zero too
      if ((sel > 4'hB) || (pos > 6'h1F)) begin
         row_bit = 1'b0;
      end else begin
         row_bit = sys_addr[pos[4:0]];
      end
   end
endmodule : row_bit_select
`default_nettype wire

/* hdl/dram_init_timing_rowmap.sv */
// Purpose: Upper row address map and DRAM power-up init sequencing
// Assumes: AHB-Lite slave, zero wait states, OKAY only
// Notes:   Sequence starts once software sets the start bit
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Row bit13 from address 19 plus select
// - Row bit14 from address 20 plus select
// - Row bit15 from address 21 plus select
// - Wait 32-cycle ticks before calibration complete
// - Wait 32-cycle ticks before scheduler start
// - Skip bit: default and exit, no adjust
// - Wait pre-enable count times 1024 before enable
// - Pre-enable low byte in bits 15:8
// - Pre-enable upper bits in second register
// - Hold memory reset for programmed count
module dram_init_timing_rowmap (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [31:0] sys_addr,
   output logic [2:0]       row_upper,
   output logic             mem_reset_n,
   output logic             clock_enable,
   output dram_init_pkg::init_cmd_t init_cmd,
   output logic             sched_enable
);
   import dram_init_pkg::*;

   // ==========================================================
   // Register storage
   // Only implemented bits are stored; reserved bits read zero
   logic [11:0] row_map;         // Three 4-bit selects
   logic [11:0] init_wait;       // Pre-cal, post wait, skip
   logic [15:0] rst_cke_lo;      // Pre-enable low, reset length
   logic [1:0]  pre_cke_hi;      // Pre-enable upper bits
   logic        start_req;       // Software start pulse
   // Bus pipeline
   logic        wr_pend;         // Data phase of a write
   logic [7:0]  wr_addr;         // Latched write offset
   // Sequencer
   init_state_t state;           // Current init step
   logic [19:0] wait_cnt;        // Ticks or clocks left
   logic [4:0]  tick_div;        // Global 32-cycle timer
   logic        tick32;          // One pulse per 32 clocks
   logic        done;            // Sequence finished
   logic [2:0]  next_row;        // Combinational row bits
   logic        access;          // Valid address phase

   // Word-aligned offset of a bus address
   // Upper address bits are ignored, so the map repeats
   function automatic logic [7:0] reg_off(input logic [31:0] a);
      reg_off = {a[7:2], 2'b00};
   endfunction : reg_off

   // Assembled pre-enable count in 1024-cycle units
   function automatic logic [9:0] pre_cke_val(
      input logic [1:0] hi, input logic [15:0] lo);
      pre_cke_val = {hi, lo[pre_cke_lo_lsb +: 8]};
   endfunction : pre_cke_val

   assign access = hsel & hready & htrans[1];

   // ==========================================================
   // Bus address phase capture
   // Writes land one edge later, when hwdata stands
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= access & hwrite;
         if (access) begin
            wr_addr <= reg_off(haddr);
         end
      end
   end

   // ==========================================================
   // Register writes; reserved bits are not stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_map    <= row_map_upper_rst[11:0];
         init_wait  <= init_wait_ctrl_rst[11:0];
         rst_cke_lo <= rst_cke_lo_rst[15:0];
         pre_cke_hi <= rst_cke_hi_rst[1:0];
         start_req  <= 1'b0;
      end else begin
         // Start is a one-cycle pulse and is never stored
         start_req <= 1'b0;
         if (wr_pend) begin
            unique case (wr_addr)
               row_map_upper_off:  row_map    <= hwdata[11:0];
               init_wait_ctrl_off: init_wait  <= hwdata[11:0];
               rst_cke_lo_off:     rst_cke_lo <= hwdata[15:0];
               rst_cke_hi_off:     pre_cke_hi <= hwdata[1:0];
               init_ctrl_off:      start_req  <= hwdata[0];
               default: ;  // Unmapped writes are dropped
            endcase
         end
      end
   end

   // ==========================================================
   // Read data, registered in the address phase
   // Start register and holes read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (access && !hwrite) begin
         unique case (reg_off(haddr))
            row_map_upper_off:  hrdata <= {20'h00000, row_map};
            init_wait_ctrl_off: hrdata <= {20'h00000, init_wait};
            rst_cke_lo_off:     hrdata <= {16'h0000, rst_cke_lo};
            rst_cke_hi_off:     hrdata <= {30'h0, pre_cke_hi};
            init_status_off:    hrdata <= {27'h0, done, state};
            default:            hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Zero wait states, always OKAY
   // All read data comes from flops, so no stall is ever needed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ==========================================================
   // Upper row address mapping
   row_bit_select #(.base(row_b13_base)) u_b13 (
      .sys_addr (sys_addr),
      .sel      (row_map[row_b13_lsb +: 4]),
      .row_bit  (next_row[0])
   );
   row_bit_select #(.base(row_b14_base)) u_b14 (
      .sys_addr (sys_addr),
      .sel      (row_map[row_b14_lsb +: 4]),
      .row_bit  (next_row[1])
   );
   row_bit_select #(.base(row_b15_base)) u_b15 (
      .sys_addr (sys_addr),
      .sel      (row_map[row_b15_lsb +: 4]),
      .row_bit  (next_row[2])
   );

   // Registered so the output comes from a flip-flop
   // One clock of latency from sys_addr to row_upper
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_upper <= 3'b000;
      end else begin
         row_upper <= next_row;
      end
   end

   // ==========================================================
   // Global timer, one pulse every 32 clocks
   // Free running: a wait that uses it sees its first tick anywhere
   // from 1 to 32 clocks after it begins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_div <= 5'h00;
         tick32   <= 1'b0;
      end else begin
         tick_div <= tick_div + 5'h01;
         tick32   <= (tick_div == 5'(tick32_cycles - 1));
      end
   end

   // ==========================================================
   // Init sequencer; each step up to the final wait, bar the exit command, counts down wait_cnt then moves on.
   // Clock-based waits count clocks, 32-cycle waits count ticks.
   // Order: memory reset, pre-enable wait, clock enable, default
   // command, pre-calibration wait, exit command, final wait, and
   // last the scheduler. Each step is entered only from the one
   // before it, so no setting can reorder the sequence.
   // The counter is 20 bits so that the largest pre-enable count,
   // 1023 units of 1024 clocks, fits without wrapping.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // Memory held in reset and clock disabled from power-up
         state        <= st_idle;
         wait_cnt     <= 20'h00000;
         mem_reset_n  <= 1'b0;
         clock_enable <= 1'b0;
         init_cmd     <= cmd_none;
         sched_enable <= 1'b0;
         done         <= 1'b0;
      end else begin
         // Commands are one-cycle pulses unless a step issues one
         init_cmd <= cmd_none;
         unique case (state)
            st_idle: begin
               // Hold memory in reset until software starts
               if (start_req) begin
                  state       <= st_mem_rst;
                  // Already low from power-up; kept low explicitly
                  mem_reset_n <= 1'b0;
                  // Reset length counts whole clocks
                  wait_cnt <= {12'h000, rst_cke_lo[mem_rst_lsb +: 8]};
               end
            end
            st_mem_rst: begin
               // Zero count releases reset on the next clock
               if (wait_cnt != 20'h00000) begin
                  wait_cnt <= wait_cnt - 20'h00001;
               end else begin
                  mem_reset_n <= 1'b1;
                  state       <= st_pre_cke;
                  // 1024 clocks per unit of the pre-enable count
                  wait_cnt <= {pre_cke_val(pre_cke_hi, rst_cke_lo),
                               10'h000};
               end
            end
            st_pre_cke: begin
               // Memory out of reset, clock still disabled
               if (wait_cnt != 20'h00000) begin
                  wait_cnt <= wait_cnt - 20'h00001;
               end else begin
                  // Clock enable stays high from here on
                  clock_enable <= 1'b1;
                  state        <= st_cke_on;
                  wait_cnt     <= 20'(cmd_gap_cycles);
               end
            end
            st_cke_on: begin
               // Short settling gap before the first command
               if (wait_cnt != 20'h00000) begin
                  wait_cnt <= wait_cnt - 20'h00001;
               end else begin
                  // Skip set: default step, no adjust step
                  init_cmd <= init_wait[skip_bit] ? cmd_cal_dflt
                                                  : cmd_cal_adj;
                  state    <= st_cal_dflt;
                  wait_cnt <= 20'(cmd_gap_cycles);
               end
            end
            st_cal_dflt: begin
               // Same fixed gap after the default command
               if (wait_cnt != 20'h00000) begin
                  wait_cnt <= wait_cnt - 20'h00001;
               end else begin
                  state    <= st_pre_cal;
                  wait_cnt <= {16'h0000, init_wait[pre_cal_lsb +: 4]};
               end
            end
            st_pre_cal: begin
               // Counts global ticks; zero passes straight through.
               // The timer runs free, so the real wait may be up to
               // 31 clocks shorter than the ticks times 32.
               if (wait_cnt == 20'h00000) begin
                  init_cmd <= cmd_cal_exit;
                  state    <= st_cal_exit;
                  wait_cnt <= {13'h0000, init_wait[post_wait_lsb +: 7]};
               end else if (tick32) begin
                  wait_cnt <= wait_cnt - 20'h00001;
               end
            end
            st_cal_exit: begin
               // One cycle for the exit command to leave the pins
               state <= st_final;
            end
            st_final: begin
               // Scheduler held off for the programmed tick count
               if (wait_cnt == 20'h00000) begin
                  sched_enable <= 1'b1;
                  done         <= 1'b1;
                  state        <= st_run;
               end else if (tick32) begin
                  wait_cnt <= wait_cnt - 20'h00001;
               end
            end
            st_run: begin
               // Stays here until the next reset; a second start
               // write is ignored, the sequence is one shot
               state <= st_run;
            end
            default: begin
               // Unused state codes fall back to idle
               state <= st_idle;
            end
         endcase
      end
   end
endmodule : dram_init_timing_rowmap
`default_nettype wire

/* sim/dram_init_timing_rowmap_assertions.sv */
// Purpose: Temporal checks on the init sequencing outputs
// Assumes: Software keeps the calibration skip bit at one
// Notes:   Sees only top ports; bound below the module
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checker
module init_seq_assertions
   import dram_init_pkg::*;
(
   input wire logic      hclk,
   input wire logic      hresetn,
   input wire logic      mem_reset_n,
   input wire logic      clock_enable,
   input wire init_cmd_t init_cmd,
   input wire logic      sched_enable
);
   // One domain, so one clock and one disable for all
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_rst_first; !mem_reset_n |-> !clock_enable; endproperty
   a_rst_first: assert property (p_rst_first)
      else $error("clock enable during memory reset");
   property p_rst_hold; mem_reset_n |=> mem_reset_n; endproperty
   a_rst_hold: assert property (p_rst_hold)
      else $error("memory reset asserted again");
   property p_ce_late; $rose(mem_reset_n) |-> !clock_enable[*2]; endproperty
   a_ce_late: assert property (p_ce_late)
      else $error("clock enable too soon");
   property p_ce_hold; clock_enable |=> clock_enable; endproperty
   a_ce_hold: assert property (p_ce_hold)
      else $error("clock enable dropped");
   property p_first_cmd;
      $rose(clock_enable) |-> ##[4:6] init_cmd == cmd_cal_dflt;
   endproperty
   a_first_cmd: assert property (p_first_cmd)
      else $error("no calibration default after enable");
   property p_pulse; init_cmd != cmd_none |=> init_cmd == cmd_none; endproperty
   a_pulse: assert property (p_pulse)
      else $error("command longer than one cycle");
   property p_cmd_late; init_cmd != cmd_none |-> $past(clock_enable, 3);
   endproperty
   a_cmd_late: assert property (p_cmd_late)
      else $error("command before clock enable");
   // Bound covers fifteen ticks of the 32-cycle timer
   property p_exit;
      init_cmd == cmd_cal_dflt |-> ##[6:600] init_cmd == cmd_cal_exit;
   endproperty
   a_exit: assert property (p_exit)
      else $error("calibration exit missing");
   property p_no_adj; init_cmd != cmd_cal_adj; endproperty
   a_no_adj: assert property (p_no_adj)
      else $error("adjust step issued with skip set");
   property p_sched; sched_enable |-> clock_enable ##1 sched_enable;
   endproperty
   a_sched: assert property (p_sched)
      else $error("scheduler state wrong");
endmodule : init_seq_assertions
bind dram_init_timing_rowmap init_seq_assertions u_chk (
   .hclk(hclk), .hresetn(hresetn), .mem_reset_n(mem_reset_n),
   .clock_enable(clock_enable), .init_cmd(init_cmd),
   .sched_enable(sched_enable));
`default_nettype wire

/* sim/dram_mem_model.sv */
// Purpose: Memory side model, logs init pin activity
// Assumes: Commands are one-cycle codes on init_cmd
// Notes:   Drives nothing back; counts feed the bench
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Memory model
module dram_mem_model
   import dram_init_pkg::*;
(
   input  wire logic      hclk,
   input  wire logic      mem_reset_n,
   input  wire logic      clock_enable,
   input  wire init_cmd_t init_cmd,
   output int             ce_wait,
   output int             cal_gap,
   output int             dflt_cnt,
   output int             exit_cnt,
   output int             early_cnt
);
   logic gap_on = 1'b0; // Between default and exit
   initial begin
      {ce_wait, cal_gap, dflt_cnt, exit_cnt, early_cnt} = '0;
   end
   // Sample pins as a real device would, one edge at a time
   always @(posedge hclk) begin
      if (mem_reset_n && !clock_enable) ce_wait <= ce_wait + 1;
      if (init_cmd != cmd_none && !clock_enable) early_cnt <= early_cnt + 1;
      if (init_cmd == cmd_cal_dflt) begin
         dflt_cnt <= dflt_cnt + 1;
         gap_on   <= 1'b1;
      end
      if (gap_on) cal_gap <= cal_gap + 1;
      if (init_cmd == cmd_cal_exit) begin
         exit_cnt <= exit_cnt + 1;
         gap_on   <= 1'b0;
      end
   end
endmodule : dram_mem_model
`default_nettype wire

/* sim/tb.sv */
// Purpose: Register, init sequence and row map tests
// Assumes: Zero wait slave, hready fed from hreadyout
// Notes:   Pre-enable of 40 units meets the power-up minimum
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench
module tb;
   import dram_init_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, sys_addr = '0, hrdata, r, v;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2; // Word transfers only
   logic        hreadyout, hresp, mem_reset_n, clock_enable, sched_enable;
   logic [2:0]  row_upper, e;
   init_cmd_t   init_cmd;
   int          ce_wait, cal_gap, dflt_cnt, exit_cnt, early_cnt;
   int          error_cnt = 0, checks_done = 0, cycles = 0, n, s;
   logic [7:0]  offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
   logic [31:0] rstv[5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
   logic [31:0] mask[5] = '{32'hFFF, 32'hFFF, 32'hFFFF, 32'h3, 32'h0};
   int          sels[4] = '{0, 7, 10, 15};
   always #2.5 hclk = ~hclk;
   dram_init_timing_rowmap DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sys_addr(sys_addr), .row_upper(row_upper),
      .mem_reset_n(mem_reset_n), .clock_enable(clock_enable),
      .init_cmd(init_cmd), .sched_enable(sched_enable));
   dram_mem_model u_mem (.hclk(hclk), .mem_reset_n(mem_reset_n),
      .clock_enable(clock_enable), .init_cmd(init_cmd),
      .ce_wait(ce_wait), .cal_gap(cal_gap), .dflt_cnt(dflt_cnt),
      .exit_cnt(exit_cnt), .early_cnt(early_cnt));
   // One AHB single transfer; waits on hready, never on a count
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // Hang guard, above the roughly 41200 cycles needed
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 45000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset values, then writable field widths; 0x20 is unmapped
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, offs[i], 32'h0, r);
         check("reset value", r, rstv[i]);
         check("okay response", hresp, 32'h0);
      end
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, offs[i], 32'hFFFF_FFFF, r);
         bus(1'b0, offs[i], 32'h0, r);
         check("field mask", r, mask[i]);
      end
      $display("test registers done");
      // Pre-enable 40 (about 205 us), reset length 3, pre-cal 2,
      // final wait 1; init wait is read, modified and written back
      bus(1'b1, rst_cke_lo_off, 32'h0000_2803, r);
      bus(1'b1, rst_cke_hi_off, 32'h0, r);
      bus(1'b0, init_wait_ctrl_off, 32'h0, r);
      bus(1'b1, init_wait_ctrl_off, {r[31:12], 12'h203}, r);
      check("enable before start", clock_enable, 32'h0);
      bus(1'b1, init_ctrl_off, 32'h1, r);
      n = 0;
      while (mem_reset_n !== 1'b1) begin
         @(posedge hclk);
         n++;
      end
      // Start acts one clock after its data phase, plus one of sampling
      check("reset length", n, 32'd6);
      while (exit_cnt == 0) @(posedge hclk);
      check("pre enable", ce_wait, 32'(40 * tick1024_cycles + 1));
      check("calibration gap", cal_gap inside {[38:71]}, 32'h1);
      check("default count", dflt_cnt, 32'h1);
      check("early commands", early_cnt, 32'h0);
      n = 0;
      while (sched_enable !== 1'b1) begin
         @(posedge hclk);
         n++;
      end
      check("final wait", n inside {[0:34]}, 32'h1);
      bus(1'b0, init_status_off, 32'h0, r);
      check("status", r, {27'h0, 1'b1, st_run});
      $display("test init sequence done");
      // Two patterns per select; select 15 must give zero
      for (int k = 0; k < 4; k++) begin
         s = sels[k];
         bus(1'b1, row_map_upper_off, {20'h0, s[3:0], s[3:0], s[3:0]}, r);
         v = (32'h1 << (19 + s)) | (32'h1 << (21 + s));
         for (int b = 0; b < 2; b++) begin
            sys_addr <= b ? ~v : v;
            e = (s == 15) ? 3'b000 : (b ? 3'b010 : 3'b101);
            repeat (2) @(posedge hclk);
            check("row bits", row_upper, e);
         end
      end
      $display("test row map done");
      wrap_up();
   end
endmodule : tb
`default_nettype wire
